// ---- design/cts_defines.svh ----
// Constants for the cell transmission convergence block
`ifndef CTS_DEFINES_SVH
`define CTS_DEFINES_SVH
`define CTS_CELL_LEN 6'h35
`define CTS_HEC_IDX 6'h04
`define CTS_PAIR_LAST 4'h9
`define CTS_SYM_ESC 5'h02
`define CTS_SYM_SOC 5'h07
`define CTS_SYM_SYNC 5'h12
`define CTS_HEC_POLY 8'h07
`define CTS_HEC_COSET 8'h55
`endif

// ---- design/cts_pkg.sv ----
// Types shared by the convergence block and its bench
package cts_pkg;
   typedef struct packed {
      logic soc;
      logic [7:0] data;
   } cts_beat_s;
   typedef enum logic [1:0] {PAIR_FILL, PAIR_SOC, PAIR_SYNC, PAIR_DATA} cts_pair_e;
endpackage

// ---- design/cts_fifo.sv ----
// Small synchronous FIFO with registered flags
`timescale 1ns/1ps
module cts_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [WIDTH-1:0] inData,
   input wire logic inValid,
   output logic inReady,
   output logic [WIDTH-1:0] outData,
   output logic outValid,
   input wire logic outReady
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wrPtr;
   logic [AW-1:0] rdPtr;
   logic [AW:0] count;
   logic [AW:0] next_count;
   logic push;
   logic pop;

   assign push = inValid && inReady;
   assign pop = outValid && outReady;
   assign outData = mem[rdPtr];

   always_comb begin
      next_count = count;
      if (push && !pop) begin
         next_count = count + 1'b1;
      end else if (pop && !push) begin
         next_count = count - 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wrPtr] <= inData;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
         inReady <= 1'b0;
         outValid <= 1'b0;
      end else begin
         if (push) begin
            wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
         end
         if (pop) begin
            rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
         end
         count <= next_count;
         // Flags come from the next count so they stay honest every cycle
         inReady <= next_count != (AW + 1)'(DEPTH);
         outValid <= next_count != '0;
      end
   end
endmodule

// ---- design/cts_core.sv ----
// Transmission convergence: pair framing, NRZI, HEC, cell delineation
`timescale 1ns/1ps
`include "cts_defines.svh"
module cts_core #(
   parameter int BIT_DIV = 1,
   parameter bit WRAP_SYNC = 1'b0
) (
   input wire logic clk,
   input wire logic nrst,
   input wire cts_pkg::cts_beat_s txBeat,
   input wire logic txValid,
   output logic txReady,
   input wire logic txScrReset,
   input wire logic syncIn,
   output logic lineOut,
   output logic txUnderrun,
   input wire logic lineIn,
   output cts_pkg::cts_beat_s rxBeat,
   output logic rxValid,
   output logic rxSyncPulse,
   output logic rxCmdErr,
   output logic rxHecErr
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   function automatic logic [7:0] crc8(input logic [7:0] crc, input logic [7:0] d);
      logic [7:0] c;
      c = crc ^ d;
      for (int i = 0; i < 8; i++) begin
         c = c[7] ? ((c << 1) ^ `CTS_HEC_POLY) : (c << 1);
      end
      return c;
   endfunction

   function automatic logic [4:0] enc(input logic [3:0] n);
      logic [4:0] t [16];
      t = '{5'h15, 5'h09, 5'h0a, 5'h0b, 5'h07, 5'h0d, 5'h0e, 5'h0f,
            5'h12, 5'h19, 5'h1a, 5'h1b, 5'h17, 5'h1d, 5'h1e, 5'h1f};
      return t[n];
   endfunction

   // Returns {valid, nibble}; one loop over the table keeps it in one place
   function automatic logic [4:0] dec(input logic [4:0] s);
      for (int i = 0; i < 16; i++) begin
         if (enc(4'(i)) == s) begin
            return {1'b1, 4'(i)};
         end
      end
      return 5'h00;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Bit rate enable
   logic [7:0] divCnt;
   logic bitEn;
   always_ff @(posedge clk) begin
      if (!nrst) begin
         divCnt <= 8'h00;
         bitEn <= 1'b0;
      end else begin
         divCnt <= (divCnt == 8'(BIT_DIV - 1)) ? 8'h00 : divCnt + 8'h01;
         bitEn <= divCnt == 8'(BIT_DIV - 1);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Transmit FIFO and pair selection
   cts_pkg::cts_beat_s fifoBeat;
   logic fifoValid;
   logic fifoPop;
   cts_fifo #(.WIDTH($bits(cts_pkg::cts_beat_s)), .DEPTH(8)) u_fifo (
      .clk(clk),
      .nrst(nrst),
      .inData(txBeat),
      .inValid(txValid),
      .inReady(txReady),
      .outData(fifoBeat),
      .outValid(fifoValid),
      .outReady(fifoPop)
   );

   logic syncS1, syncS2, syncS3;
   logic syncPend, wrapEvt, pairLoad;
   logic [3:0] txBitCnt;
   logic [9:0] shifter, next_pair;
   logic [5:0] txLeft, txIdx;
   logic [7:0] txCrc, fillCnt, txOctet;
   cts_pkg::cts_pair_e next_kind, txKind;

   assign pairLoad = bitEn && (txBitCnt == `CTS_PAIR_LAST);
   assign txIdx = `CTS_CELL_LEN - txLeft;

   always_comb begin
      next_kind = cts_pkg::PAIR_FILL;
      fifoPop = 1'b0;
      txOctet = fillCnt;
      if (syncPend) begin
         next_kind = cts_pkg::PAIR_SYNC;
      end else if (txLeft != 6'h00) begin
         if (fifoValid) begin
            next_kind = cts_pkg::PAIR_DATA;
            fifoPop = pairLoad;
            txOctet = (txIdx == `CTS_HEC_IDX) ? (txCrc ^ `CTS_HEC_COSET)
                                              : fifoBeat.data;
         end
      end else if (fifoValid && fifoBeat.soc) begin
         next_kind = cts_pkg::PAIR_SOC;
      end else if (fifoValid) begin
         // Stray octet outside a cell cannot form a whole cell
         fifoPop = pairLoad;
      end
      case (next_kind)
         cts_pkg::PAIR_SYNC: next_pair = {`CTS_SYM_ESC, `CTS_SYM_SYNC};
         cts_pkg::PAIR_SOC: next_pair = {`CTS_SYM_ESC, txScrReset ? `CTS_SYM_ESC
                                                                  : `CTS_SYM_SOC};
         default: next_pair = {enc(txOctet[7:4]), enc(txOctet[3:0])};
      endcase
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         syncS1 <= 1'b0;
         syncS2 <= 1'b0;
         syncS3 <= 1'b0;
         syncPend <= 1'b0;
      end else begin
         syncS1 <= syncIn;
         syncS2 <= syncS1;
         syncS3 <= syncS2;
         // A new event in the load cycle keeps the flag set
         if ((syncS2 && !syncS3) || wrapEvt) begin
            syncPend <= 1'b1;
         end else if (pairLoad) begin
            syncPend <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         txBitCnt <= 4'h0;
         shifter <= 10'h000;
         lineOut <= 1'b0;
         txKind <= cts_pkg::PAIR_FILL;
      end else if (bitEn) begin
         lineOut <= lineOut ^ shifter[9];
         // Fixed ten-bit pair frame from reset keeps commands aligned
         txBitCnt <= pairLoad ? 4'h0 : txBitCnt + 4'h1;
         shifter <= pairLoad ? next_pair : {shifter[8:0], 1'b0};
         if (pairLoad) begin
            txKind <= next_kind;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         txLeft <= 6'h00;
         txCrc <= 8'h00;
         fillCnt <= 8'h00;
         txUnderrun <= 1'b0;
      end else begin
         txUnderrun <= pairLoad && !syncPend && txLeft != 6'h00 && !fifoValid;
         if (pairLoad) begin
            fillCnt <= fillCnt + 8'h01;
            if (next_kind == cts_pkg::PAIR_SOC) begin
               txLeft <= `CTS_CELL_LEN;
               txCrc <= 8'h00;
            end else if (next_kind == cts_pkg::PAIR_DATA) begin
               txLeft <= txLeft - 6'h01;
               if (txIdx < `CTS_HEC_IDX) begin
                  txCrc <= crc8(txCrc, fifoBeat.data);
               end
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Receive: sync, NRZI decode, pair alignment
   logic rxS1, rxS2, rxS3;
   logic rxBit, rxAligned, rxPairEnd, rxIsCmd, rxInCell, draining;
   logic [9:0] rxWin, next_rxWin;
   logic [3:0] rxBitCnt;
   logic [4:0] decHi, decLo;
   logic [5:0] rxCnt, rdIdx;
   logic [7:0] rxCrc;
   logic [7:0] cellMem [64];

   assign rxBit = rxS2 ^ rxS3;
   assign next_rxWin = {rxWin[8:0], rxBit};
   assign rxIsCmd = next_rxWin[9:5] == `CTS_SYM_ESC &&
                    (next_rxWin[4:0] == `CTS_SYM_ESC || next_rxWin[4:0] == `CTS_SYM_SOC ||
                     next_rxWin[4:0] == `CTS_SYM_SYNC);
   // Unaligned hunt relies on the escape symbol being unique among pairs
   assign rxPairEnd = bitEn && (rxAligned ? rxBitCnt == `CTS_PAIR_LAST : rxIsCmd);
   assign decHi = dec(next_rxWin[9:5]);
   assign decLo = dec(next_rxWin[4:0]);

   always_ff @(posedge clk) begin
      if (!nrst) begin
         rxS1 <= 1'b0;
         rxS2 <= 1'b0;
         rxS3 <= 1'b0;
         rxWin <= 10'h000;
         rxBitCnt <= 4'h0;
         rxAligned <= 1'b0;
      end else begin
         rxS1 <= lineIn;
         rxS2 <= rxS1;
         if (bitEn) begin
            rxS3 <= rxS2;
            rxWin <= next_rxWin;
            rxBitCnt <= rxPairEnd ? 4'h0 : rxBitCnt + 4'h1;
         end
         if (rxPairEnd) begin
            if (next_rxWin[9:5] == `CTS_SYM_ESC) begin
               rxAligned <= 1'b1;
            end else if (!decHi[4] || !decLo[4]) begin
               rxAligned <= 1'b0;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Receive: commands, cell capture, header check
   always_ff @(posedge clk) begin
      if (!nrst) begin
         rxInCell <= 1'b0;
         rxCnt <= 6'h00;
         rxCrc <= 8'h00;
         rxSyncPulse <= 1'b0;
         rxCmdErr <= 1'b0;
         rxHecErr <= 1'b0;
         wrapEvt <= 1'b0;
      end else begin
         rxSyncPulse <= 1'b0;
         rxCmdErr <= 1'b0;
         rxHecErr <= 1'b0;
         wrapEvt <= 1'b0;
         if (rxPairEnd && next_rxWin[9:5] == `CTS_SYM_ESC) begin
            if (next_rxWin[4:0] == `CTS_SYM_ESC || next_rxWin[4:0] == `CTS_SYM_SOC) begin
               rxInCell <= 1'b1;
               rxCnt <= 6'h00;
               rxCrc <= 8'h00;
            end else if (next_rxWin[4:0] == `CTS_SYM_SYNC) begin
               rxSyncPulse <= 1'b1;
               wrapEvt <= WRAP_SYNC;
            end else if (rxInCell) begin
               rxCmdErr <= 1'b1;
               rxInCell <= 1'b0;
            end
         end else if (rxPairEnd && rxInCell) begin
            if (!decHi[4] || !decLo[4]) begin
               rxCmdErr <= 1'b1;
               rxInCell <= 1'b0;
            end else begin
               rxCnt <= rxCnt + 6'h01;
               if (rxCnt < `CTS_HEC_IDX) begin
                  rxCrc <= crc8(rxCrc, {decHi[3:0], decLo[3:0]});
               end
               // Detection only: a mismatch drops the cell, no bit repair
               if (rxCnt == `CTS_HEC_IDX &&
                   (rxCrc ^ `CTS_HEC_COSET) != {decHi[3:0], decLo[3:0]}) begin
                  rxHecErr <= 1'b1;
                  rxInCell <= 1'b0;
               end
               if (rxCnt == `CTS_CELL_LEN - 6'h01) begin
                  rxInCell <= 1'b0;
               end
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rxPairEnd && rxInCell && next_rxWin[9:5] != `CTS_SYM_ESC) begin
         cellMem[rxCnt] <= {decHi[3:0], decLo[3:0]};
      end
   end

   // Drain at one octet per clock outruns the writer of the next cell
   logic cellDone;
   assign cellDone = rxPairEnd && rxInCell && next_rxWin[9:5] != `CTS_SYM_ESC &&
                     decHi[4] && decLo[4] && rxCnt == `CTS_CELL_LEN - 6'h01;
   always_ff @(posedge clk) begin
      if (!nrst) begin
         draining <= 1'b0;
         rdIdx <= 6'h00;
         rxValid <= 1'b0;
         rxBeat <= '0;
      end else begin
         rxValid <= draining;
         rxBeat.soc <= draining && rdIdx == 6'h00;
         rxBeat.data <= cellMem[rdIdx];
         if (cellDone) begin
            draining <= 1'b1;
            rdIdx <= 6'h00;
         end else if (draining) begin
            rdIdx <= rdIdx + 6'h01;
            draining <= rdIdx != `CTS_CELL_LEN - 6'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   a_sync_first: assert property (pairLoad && syncPend
      |=> shifter == {`CTS_SYM_ESC, `CTS_SYM_SYNC}) else $error("sync marker not sent");
   a_sync_wait: assert property ($rose(syncPend) |-> ##[0:20] (pairLoad && syncPend))
      else $error("sync marker waited past a pair");
   a_cell_contig: assert property (pairLoad && !syncPend && txLeft != 6'h00 && fifoValid
      |=> txKind == cts_pkg::PAIR_DATA && txLeft == $past(txLeft) - 6'h01)
      else $error("cell data pair not sent");
   a_soc_start: assert property (pairLoad && !syncPend && txLeft == 6'h00 && fifoValid
      && fifoBeat.soc |=> txLeft == `CTS_CELL_LEN && shifter[9:5] == `CTS_SYM_ESC)
      else $error("start of cell delayed");
   a_idle_fill: assert property (pairLoad && !syncPend && txLeft == 6'h00 && !fifoValid
      |=> shifter[9:5] != `CTS_SYM_ESC) else $error("idle pair not fill data");
   a_nrzi_tx: assert property (bitEn
      |=> lineOut == ($past(lineOut) ^ $past(shifter[9]))) else $error("line not NRZI coded");
   a_hec_insert: assert property (pairLoad && next_kind == cts_pkg::PAIR_DATA
      && txIdx == `CTS_HEC_IDX |=> shifter == {enc($past(txCrc[7:4]) ^ 4'h5),
      enc($past(txCrc[3:0]) ^ 4'h5)}) else $error("header check octet wrong");
   a_cmd_error: assert property (rxPairEnd && rxInCell && !rxIsCmd
      && next_rxWin[9:5] == `CTS_SYM_ESC |=> rxCmdErr && !rxInCell)
      else $error("bad command inside cell not flagged");
   a_soc_restart: assert property (rxPairEnd && rxIsCmd
      && next_rxWin[4:0] != `CTS_SYM_SYNC |=> rxInCell && rxCnt == 6'h00)
      else $error("start of cell did not restart capture");
   a_hec_drop: assert property (rxHecErr |-> !rxInCell ##1 !cellDone [*8])
      else $error("cell kept after header check failure");
   c_sync_in_cell: cover property (pairLoad && syncPend && txLeft != 6'h00);
   c_rx_cell: cover property (rxValid && rxBeat.soc);
   c_hec_err: cover property (rxHecErr);
endmodule

// ---- verif/cts_far_end.sv ----
// Far-end line model: frames the serial output and drives the serial input
`timescale 1ns/1ps
`include "cts_defines.svh"
module cts_far_end (
   input wire logic clk,
   input wire logic nrst,
   input wire logic lineOut,
   output logic lineIn,
   output logic gotCmd,
   output logic gotOct,
   output logic gotFill,
   output logic [7:0] gotVal,
   output logic badSym
);
   logic [9:0] txQ[$];
   logic [9:0] txPair;
   logic [9:0] sh;
   logic [3:0] txBit;
   logic [3:0] rxBit;
   logic [5:0] cellLeft;
   logic prevLine;
   logic aligned;
   function automatic logic [4:0] enc(input logic [3:0] n);
      logic [4:0] t[16];
      t = '{5'h15, 5'h09, 5'h0a, 5'h0b, 5'h07, 5'h0d, 5'h0e, 5'h0f,
            5'h12, 5'h19, 5'h1a, 5'h1b, 5'h17, 5'h1d, 5'h1e, 5'h1f};
      return t[n];
   endfunction
   // Gives {valid, nibble}
   function automatic logic [4:0] dec(input logic [4:0] s);
      for (int i = 0; i < 16; i++) begin
         if (enc(4'(i)) == s) begin
            return {1'b1, 4'(i)};
         end
      end
      return 5'h00;
   endfunction
   function automatic logic isCmd(input logic [9:0] w);
      return w[9:5] == `CTS_SYM_ESC && w[4:0] inside {`CTS_SYM_ESC, `CTS_SYM_SOC, `CTS_SYM_SYNC};
   endfunction
   task automatic pushPair(input logic [9:0] p);
      txQ.push_back(p);
   endtask
   task automatic pushOct(input logic [7:0] d);
      txQ.push_back({enc(d[7:4]), enc(d[3:0])});
   endtask
   ////////////////////////////////////////
   // Fill is a constant valid pair, so the comma stays unique
   always @(posedge clk) begin
      if (!nrst) begin
         lineIn <= 1'b0;
         txBit <= 4'h0;
         txPair <= 10'h2b5;
      end else begin
         lineIn <= lineIn ^ txPair[4'h9 - txBit];
         txBit <= (txBit == 4'h9) ? 4'h0 : txBit + 4'h1;
         if (txBit == 4'h9) begin
            txPair <= (txQ.size() != 0) ? txQ.pop_front() : 10'h2b5;
         end
      end
   end
   ////////////////////////////////////////
   // Pair framing is fixed by the first command seen
   always @(posedge clk) begin
      logic [9:0] w;
      logic [4:0] hi;
      logic [4:0] lo;
      w = {sh[8:0], lineOut ^ prevLine};
      hi = dec(w[9:5]);
      lo = dec(w[4:0]);
      sh <= w;
      prevLine <= lineOut;
      gotCmd <= 1'b0;
      gotOct <= 1'b0;
      gotFill <= 1'b0;
      if (!nrst) begin
         sh <= 10'h000;
         prevLine <= 1'b0;
         aligned <= 1'b0;
         rxBit <= 4'h0;
         cellLeft <= 6'h00;
         badSym <= 1'b0;
      end else if (aligned ? rxBit == 4'h9 : isCmd(w)) begin
         aligned <= 1'b1;
         rxBit <= 4'h0;
         gotVal <= {hi[3:0], lo[3:0]};
         if (w[9:5] == `CTS_SYM_ESC) begin
            gotCmd <= 1'b1;
            gotVal <= {3'h0, w[4:0]};
            badSym <= badSym | !isCmd(w);
            if (w[4:0] != `CTS_SYM_SYNC) begin
               cellLeft <= 6'h35;
            end
         end else if (hi[4] && lo[4]) begin
            gotOct <= (cellLeft != 6'h00);
            gotFill <= (cellLeft == 6'h00);
            cellLeft <= (cellLeft != 6'h00) ? cellLeft - 6'h01 : cellLeft;
         end else begin
            badSym <= 1'b1;
         end
      end else if (aligned) begin
         rxBit <= rxBit + 4'h1;
      end
   end
endmodule

// ---- verif/cts_core_bench.sv ----
// Self-checking bench for the convergence core against the line model
`timescale 1ns/1ps
`include "cts_defines.svh"
module cts_core_bench;
   localparam int TMAX = 20000;
   logic clk;
   logic nrst;
   cts_pkg::cts_beat_s txBeat;
   cts_pkg::cts_beat_s rxBeat;
   logic txValid, txReady, txScrReset, syncIn, lineOut, lineIn, txUnderrun;
   logic rxValid, rxSyncPulse, rxCmdErr, rxHecErr;
   logic gotCmd, gotOct, gotFill, badSym, lastLine;
   logic lastOct = 1'b0;
   logic [7:0] gotVal;
   logic [8:0] txExp[$];
   logic [8:0] rxExp[$];
   int seed = 85;
   int miscompares, samplesChecked, cycles, syncT, syncLat, stalls, toggles;
   int nSync, nHec, nCmd, nRxSync, nUnder;
   cts_core #(.BIT_DIV(1), .WRAP_SYNC(1'b1)) u_cts_core (.clk(clk), .nrst(nrst),
      .txBeat(txBeat), .txValid(txValid), .txReady(txReady), .txScrReset(txScrReset),
      .syncIn(syncIn), .lineOut(lineOut), .txUnderrun(txUnderrun), .lineIn(lineIn),
      .rxBeat(rxBeat), .rxValid(rxValid), .rxSyncPulse(rxSyncPulse), .rxCmdErr(rxCmdErr),
      .rxHecErr(rxHecErr));
   cts_far_end u_cts_far_end (.clk(clk), .nrst(nrst), .lineOut(lineOut), .lineIn(lineIn),
      .gotCmd(gotCmd), .gotOct(gotOct), .gotFill(gotFill), .gotVal(gotVal), .badSym(badSym));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   ////////////////////////////////////////
   task automatic finish_test();
      $display("checks %0d mismatches %0d", samplesChecked, miscompares);
      if (miscompares == 0 && samplesChecked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
      samplesChecked++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   function automatic logic [7:0] hec(input logic [31:0] h);
      logic [7:0] r;
      r = 8'h00;
      for (int i = 31; i >= 0; i--) begin
         r = {r[6:0], 1'b0} ^ ((r[7] ^ h[i]) ? 8'h07 : 8'h00);
      end
      return r ^ 8'h55;
   endfunction
   task automatic tx_octet(input logic soc, input logic [7:0] d, input logic scr);
      txBeat <= {soc, d};
      txValid <= 1'b1;
      txScrReset <= scr;
      @(posedge clk);
      while (!txReady) begin
         stalls++;
         @(posedge clk);
      end
   endtask
   // Header octet five is offered wrong on purpose; the core must replace it
   task automatic tx_cell(input logic scr);
      logic [7:0] c[53];
      foreach (c[i]) c[i] = 8'($random(seed));
      c[4] = hec({c[0], c[1], c[2], c[3]});
      txExp.push_back({1'b1, 3'h0, scr ? `CTS_SYM_ESC : `CTS_SYM_SOC});
      foreach (c[i]) begin
         txExp.push_back({1'b0, c[i]});
         tx_octet(i == 0, (i == 4) ? ~c[i] : c[i], scr);
      end
   endtask
   task automatic rx_cell(input logic [4:0] cmd, input int n, input logic [7:0] flip,
                          input logic [4:0] mid);
      logic [7:0] c[53];
      foreach (c[i]) c[i] = 8'($random(seed));
      c[4] = hec({c[0], c[1], c[2], c[3]}) ^ flip;
      u_cts_far_end.pushPair({`CTS_SYM_ESC, cmd});
      for (int i = 0; i < n; i++) begin
         if (i == 20 && mid != 5'h00) begin
            u_cts_far_end.pushPair({`CTS_SYM_ESC, mid});
         end
         u_cts_far_end.pushOct(c[i]);
         if (n == 53 && flip == 8'h00 && mid inside {5'h00, `CTS_SYM_SYNC}) begin
            rxExp.push_back({i == 0, c[i]});
         end
      end
      while (u_cts_far_end.txQ.size() != 0) @(posedge clk);
      repeat (90) @(posedge clk);
   endtask
   ////////////////////////////////////////
   // Result watcher: pops the oldest note for every tx pair and rx beat except sync commands; fill pairs and error or sync pulses pop nothing
   always @(posedge clk) begin
      cycles++;
      if (nrst && lineOut !== lastLine) toggles++;
      lastLine = lineOut;
      if (txUnderrun) nUnder++;
      if (rxHecErr) nHec++;
      if (rxCmdErr) nCmd++;
      if (rxSyncPulse) nRxSync++;
      if (gotCmd && gotVal == {3'h0, `CTS_SYM_SYNC}) begin
         nSync++;
         if (nSync == 1) syncLat = cycles - syncT;
      end else if (gotCmd || gotOct) begin
         check("tx pair", {gotCmd, gotVal}, txExp.size() ? txExp.pop_front() : 9'h1ff);
         lastOct = gotOct;
      end
      if (gotFill) begin
         if (txExp.size() != 0 && (!txExp[0][8] || lastOct)) check("tx gap", 9'h000, 9'h001);
         lastOct = 1'b0;
      end
      if (rxValid) check("rx beat", rxBeat, rxExp.size() ? rxExp.pop_front() : 9'h1ff);
      if (cycles == TMAX) begin
         miscompares++;
         finish_test();
      end
   end
   initial begin
      nrst = 1'b0;
      txValid = 1'b0;
      txBeat = '0;
      txScrReset = 1'b0;
      syncIn = 1'b0;
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      repeat (100) @(posedge clk);
      check("idle toggles", 9'(toggles > 0), 9'h001);
      // Stray octets outside a cell are expected to vanish
      tx_octet(1'b0, 8'h3c, 1'b0);
      tx_octet(1'b0, 8'hc3, 1'b0);
      tx_cell(1'b1);
      tx_cell(1'b0);
      fork
         tx_cell(1'b0);
         begin
            repeat (200) @(posedge clk);
            syncIn <= 1'b1;
            syncT = cycles;
            repeat (4) @(posedge clk);
            syncIn <= 1'b0;
         end
      join
      txValid <= 1'b0;
      while (txExp.size() != 0) @(posedge clk);
      check("sync latency", 9'(syncLat >= 10 && syncLat <= 34), 9'h001);
      check("fifo refusal", 9'(stalls > 0), 9'h001);
      check("underrun", 9'(nUnder), 9'h000);
      rx_cell(`CTS_SYM_SOC, 53, 8'h00, 5'h00);
      rx_cell(`CTS_SYM_ESC, 53, 8'h00, 5'h00);
      rx_cell(`CTS_SYM_SOC, 53, 8'h01, 5'h00);
      rx_cell(`CTS_SYM_SOC, 53, 8'h00, `CTS_SYM_SYNC);
      rx_cell(`CTS_SYM_SOC, 53, 8'h00, 5'h15);
      rx_cell(`CTS_SYM_SOC, 20, 8'h00, 5'h00);
      rx_cell(`CTS_SYM_ESC, 53, 8'h00, 5'h00);
      check("hec errors", 9'(nHec), 9'h001);
      check("cmd errors", 9'(nCmd), 9'h001);
      check("rx syncs", 9'(nRxSync), 9'h001);
      check("tx syncs", 9'(nSync), 9'h002);
      check("rx left", 9'(rxExp.size()), 9'h000);
      check("line symbols", {8'h00, badSym}, 9'h000);
      finish_test();
   end
endmodule
